// *** rtl/cnm_pkg.sv ***
package cnm_pkg;
   // function codes (upper four of eleven identifier bits)
   localparam logic [3:0] FC_NMT = 4'h0;
   localparam logic [3:0] FC_SYNC_EMCY = 4'h1;
   localparam logic [3:0] FC_TIME = 4'h2;
   localparam logic [3:0] FC_TPDO1 = 4'h3;
   localparam logic [3:0] FC_RPDO4 = 4'hA;
   localparam logic [3:0] FC_SDO_TX = 4'hB;
   localparam logic [3:0] FC_SDO_RX = 4'hC;
   localparam logic [3:0] FC_ERRCTL = 4'hE;
   localparam logic [10:0] ID_NMT = 11'h000;
   localparam logic [10:0] ID_SYNC = 11'h080;
   localparam logic [10:0] ID_TIME = 11'h100;
   localparam logic [10:0] ID_EMCY_BASE = 11'h080;
   localparam logic [10:0] ID_SDO_TX_BASE = 11'h580;
   localparam logic [10:0] ID_SDO_RX_BASE = 11'h600;
   localparam logic [10:0] ID_HB_BASE = 11'h700;
   // node-control command codes
   localparam logic [7:0] CS_START = 8'h01;
   localparam logic [7:0] CS_STOP = 8'h02;
   localparam logic [7:0] CS_PREOP = 8'h80;
   localparam logic [7:0] CS_RST_APP = 8'h81;
   localparam logic [7:0] CS_RST_COM = 8'h82;
   localparam logic [6:0] NODE_BCAST = 7'h00;
   // heartbeat state bytes
   localparam logic [7:0] HB_BOOT = 8'h00;
   localparam logic [7:0] HB_STOPPED = 8'h04;
   localparam logic [7:0] HB_OPER = 8'h05;
   localparam logic [7:0] HB_PREOP = 8'h7F;
   // error register values
   localparam logic [7:0] ERREG_NONE = 8'h00;
   localparam logic [7:0] ERREG_GENERIC = 8'h01;
   localparam logic [7:0] ERREG_INTERNAL = 8'h80;
   localparam logic [15:0] OD_ERREG_INDEX = 16'h1001;
   localparam logic [15:0] EMCY_CLEAR_CODE = 16'h0000;
   // reset values and timing constants
   localparam logic [15:0] HB_CNT_RST = 16'h0000;
   localparam int CLK_HZ = 10_000_000;
   localparam int MS_NS = 1_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int TICK_CYC = MS_NS / CLK_NS;
   localparam int INIT_CYC = 2;

   typedef enum logic [5:0] {
      ST_RST_APP = 6'b000001,
      ST_RST_COM = 6'b000010,
      ST_BOOT = 6'b000100,
      ST_PREOP = 6'b001000,
      ST_OPER = 6'b010000,
      ST_STOP = 6'b100000
   } cnm_state_t;
endpackage

// *** rtl/cnm_hb_consumer.sv ***
`timescale 1ns/100ps
module cnm_hb_consumer
   import cnm_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic enable,
   input wire logic [15:0] timeout_ms,
   input wire logic seen,
   output logic lost
);
   typedef struct packed {
      logic [15:0] ms;
      logic [31:0] div;
      logic lost;
   } cnm_hbc_t;
   cnm_hbc_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (!enable || seen) begin
         s_d.ms = HB_CNT_RST;
         s_d.div = '0;
         if (seen) begin
            s_d.lost = 1'b0;
         end
      end else if (timeout_ms != HB_CNT_RST && !s_q.lost) begin
         if (s_q.div == 32'(TICK_CYCLES - 1)) begin
            s_d.div = '0;
            s_d.ms = s_q.ms + 16'h0001;
            if (s_q.ms + 16'h0001 >= timeout_ms) begin
               s_d.lost = 1'b1;
            end
         end else begin
            s_d.div = s_q.div + 32'h00000001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign lost = s_q.lost;

   a_lost_clears: assert property (@(posedge clk) disable iff (!resetn)
      seen |=> !lost) else $error("lost flag stays after heartbeat");
endmodule

// *** rtl/cnm_nmt_slave.sv ***
`timescale 1ns/100ps
module cnm_nmt_slave
   import cnm_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [6:0] node_id,
   input wire logic sync_mode,
   input wire logic [15:0] hb_prod_ms,
   input wire logic [15:0] hb_cons_ms,
   input wire logic [6:0] hb_cons_node,
   input wire logic rx_valid,
   input wire logic [10:0] rx_id,
   input wire logic [7:0] rx_byte0,
   input wire logic [7:0] rx_byte1,
   input wire logic fault,
   input wire logic [15:0] fault_code,
   input wire logic [39:0] vendor_code,
   input wire logic [15:0] od_index,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [10:0] tx_id,
   output logic [3:0] tx_len,
   output logic [63:0] tx_data,
   output logic [5:0] nmt_state,
   output logic app_reset,
   output logic pdo_rx_valid,
   output logic [1:0] pdo_rx_num,
   output logic sdo_rx_valid,
   output logic sync_pulse,
   output logic time_valid,
   output logic [7:0] err_reg,
   output logic [7:0] od_data,
   output logic hb_lost,
   output logic err_state
);
   import cnm_pkg::*;

   typedef struct packed {
      cnm_state_t st;
      logic [3:0] init_cnt;
      logic boot_pend;
      logic [7:0] cmd;
      logic cmd_pend;
      logic [15:0] hb_ms;
      logic [31:0] hb_div;
      logic hb_pend;
      logic emcy_pend;
      logic [15:0] emcy_code;
      logic fault_seen;
      logic err_state;
      logic [7:0] err_reg;
      logic tx_valid;
      logic [10:0] tx_id;
      logic [3:0] tx_len;
      logic [63:0] tx_data;
      logic app_reset;
      logic pdo_rx_valid;
      logic [1:0] pdo_rx_num;
      logic sdo_rx_valid;
      logic sync_pulse;
      logic time_valid;
      logic [7:0] od_data;
      logic hb_lost;
   } cnm_slave_t;

   cnm_slave_t s_q, s_d;
   logic lost_w;
   logic own_peer;
   logic addr_ok;
   logic cmd_known;
   logic is_run;
   logic comm_ok;
   logic hb_seen;
   logic [3:0] fc;
   logic [7:0] hb_byte;

   assign fc = rx_id[10:7];
   assign own_peer = rx_id[6:0] == node_id && node_id != NODE_BCAST;
   assign addr_ok = rx_byte1[7] == 1'b0 &&
      (rx_byte1[6:0] == NODE_BCAST || rx_byte1[6:0] == node_id);
   assign cmd_known = rx_byte0 == CS_START || rx_byte0 == CS_STOP || rx_byte0 == CS_PREOP ||
      rx_byte0 == CS_RST_APP || rx_byte0 == CS_RST_COM;
   assign is_run = s_q.st == ST_PREOP || s_q.st == ST_OPER || s_q.st == ST_STOP;
   assign comm_ok = s_q.st == ST_PREOP || s_q.st == ST_OPER;
   assign hb_seen = rx_valid && fc == FC_ERRCTL && rx_id[6:0] == hb_cons_node;

   always_comb begin
      case (s_q.st)
         ST_OPER: hb_byte = HB_OPER;
         ST_STOP: hb_byte = HB_STOPPED;
         ST_PREOP: hb_byte = HB_PREOP;
         default: hb_byte = HB_BOOT;
      endcase
   end

   // consumer timeout runs in its own counter, held cleared outside pre-operational, operational and stopped
   cnm_hb_consumer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_hbc (
      .clk(clk),
      .resetn(resetn),
      .enable(comm_ok || s_q.st == ST_STOP),
      .timeout_ms(hb_cons_ms),
      .seen(hb_seen),
      .lost(lost_w)
   );

   always_comb begin
      s_d = s_q;
      s_d.pdo_rx_valid = 1'b0;
      s_d.sdo_rx_valid = 1'b0;
      s_d.sync_pulse = 1'b0;
      s_d.time_valid = 1'b0;
      s_d.app_reset = 1'b0;
      s_d.hb_lost = lost_w;
      s_d.od_data = (od_index == OD_ERREG_INDEX) ? s_q.err_reg : 8'h00;
      if (s_q.tx_valid && tx_ready) begin
         s_d.tx_valid = 1'b0;
      end

      case (s_q.st)
         ST_RST_APP: begin
            s_d.app_reset = 1'b1;
            s_d.init_cnt = s_q.init_cnt + 4'h1;
            if (s_q.init_cnt == 4'(INIT_CYC - 1)) begin
               s_d.init_cnt = '0;
               s_d.st = ST_RST_COM;
            end
         end
         ST_RST_COM: begin
            s_d.cmd_pend = 1'b0;
            s_d.hb_ms = HB_CNT_RST;
            s_d.hb_div = '0;
            s_d.hb_pend = 1'b0;
            s_d.init_cnt = s_q.init_cnt + 4'h1;
            if (s_q.init_cnt == 4'(INIT_CYC - 1)) begin
               s_d.init_cnt = '0;
               s_d.st = ST_BOOT;
            end
         end
         ST_BOOT: begin
            s_d.boot_pend = 1'b1;
            s_d.st = ST_PREOP;
         end
         default: begin
         end
      endcase

      if (is_run && rx_valid) begin
         // node-control frame: no reply frame is ever queued for it
         if (rx_id == ID_NMT && addr_ok && cmd_known) begin
            s_d.cmd = rx_byte0;
            s_d.cmd_pend = 1'b1;
         end
         if (comm_ok && rx_id == ID_SYNC) begin
            s_d.sync_pulse = 1'b1;
         end
         if (comm_ok && rx_id == ID_TIME) begin
            s_d.time_valid = 1'b1;
         end
         if (comm_ok && fc == FC_SDO_RX && own_peer) begin
            s_d.sdo_rx_valid = 1'b1;
         end
         if (s_q.st == ST_OPER && own_peer && fc >= FC_TPDO1 && fc <= FC_RPDO4 &&
             fc[0] == 1'b0) begin
            s_d.pdo_rx_valid = 1'b1;
            s_d.pdo_rx_num = 2'((fc - 4'h4) >> 1);
         end
      end

      // synchronous mode holds the command until a sync arrives in pre-operational or operational
      if (s_q.cmd_pend && is_run &&
          (!sync_mode || (rx_valid && rx_id == ID_SYNC && comm_ok))) begin
         s_d.cmd_pend = 1'b0;
         case (s_q.cmd)
            CS_START: s_d.st = ST_OPER;
            CS_STOP: s_d.st = ST_STOP;
            CS_PREOP: s_d.st = ST_PREOP;
            CS_RST_APP: s_d.st = ST_RST_APP;
            CS_RST_COM: s_d.st = ST_RST_COM;
            default: s_d.st = s_q.st;
         endcase
      end

      // heartbeat producer, the only error-control method
      if (is_run && hb_prod_ms != HB_CNT_RST) begin
         if (s_q.hb_div == 32'(TICK_CYCLES - 1)) begin
            s_d.hb_div = '0;
            if (s_q.hb_ms + 16'h0001 >= hb_prod_ms) begin
               s_d.hb_ms = HB_CNT_RST;
               s_d.hb_pend = 1'b1;
            end else begin
               s_d.hb_ms = s_q.hb_ms + 16'h0001;
            end
         end else begin
            s_d.hb_div = s_q.hb_div + 32'h00000001;
         end
      end

      // fault edges queue emergency frames; a pending one is overwritten by the newest
      if (fault != s_q.fault_seen && is_run) begin
         s_d.fault_seen = fault;
         s_d.emcy_pend = 1'b1;
         s_d.emcy_code = fault ? fault_code : EMCY_CLEAR_CODE;
         s_d.err_reg = fault ? ERREG_GENERIC : ERREG_NONE;
         if (fault && fault_code[15:8] == 8'hFF) begin
            s_d.err_reg = ERREG_INTERNAL;
         end
      end

      // one frame at a time; boot-up first, then emergency, then heartbeat
      if (!s_q.tx_valid || tx_ready) begin
         if (s_q.boot_pend || s_d.boot_pend && s_q.st == ST_BOOT) begin
            s_d.boot_pend = 1'b0;
            s_d.tx_valid = 1'b1;
            s_d.tx_id = ID_HB_BASE + {4'h0, node_id};
            s_d.tx_len = 4'h1;
            s_d.tx_data = {56'h0, HB_BOOT};
         end else if (s_q.emcy_pend && comm_ok) begin
            s_d.emcy_pend = 1'b0;
            s_d.err_state = s_q.emcy_code != EMCY_CLEAR_CODE;
            s_d.tx_valid = 1'b1;
            s_d.tx_id = ID_EMCY_BASE + {4'h0, node_id};
            s_d.tx_len = 4'h8;
            s_d.tx_data = {vendor_code, s_d.err_reg, s_q.emcy_code[15:8],
               s_q.emcy_code[7:0]};
         end else if (s_q.hb_pend && is_run) begin
            s_d.hb_pend = 1'b0;
            s_d.tx_valid = 1'b1;
            s_d.tx_id = ID_HB_BASE + {4'h0, node_id};
            s_d.tx_len = 4'h1;
            s_d.tx_data = {56'h0, hb_byte};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
         s_q.st <= ST_RST_APP;
      end else begin
         s_q <= s_d;
      end
   end

   assign tx_valid = s_q.tx_valid;
   assign tx_id = s_q.tx_id;
   assign tx_len = s_q.tx_len;
   assign tx_data = s_q.tx_data;
   assign nmt_state = s_q.st;
   assign app_reset = s_q.app_reset;
   assign pdo_rx_valid = s_q.pdo_rx_valid;
   assign pdo_rx_num = s_q.pdo_rx_num;
   assign sdo_rx_valid = s_q.sdo_rx_valid;
   assign sync_pulse = s_q.sync_pulse;
   assign time_valid = s_q.time_valid;
   assign err_reg = s_q.err_reg;
   assign od_data = s_q.od_data;
   assign hb_lost = s_q.hb_lost;
   assign err_state = s_q.err_state;

   a_reset_seq: assert property (@(posedge clk) disable iff (!resetn)
      $rose(s_q.st == ST_RST_COM) |-> $past(s_q.st == ST_RST_APP) ||
      $past(is_run)) else $error("communication reset entered from wrong state");
   a_boot_once: assert property (@(posedge clk) disable iff (!resetn)
      s_q.st == ST_BOOT |=> s_q.st == ST_PREOP ##0 s_q.boot_pend || s_q.tx_valid)
      else $error("boot-up frame not queued");
   a_start_cmd: assert property (@(posedge clk) disable iff (!resetn)
      rx_valid && rx_id == ID_NMT && rx_byte0 == CS_START && addr_ok && is_run &&
      !sync_mode && !s_q.cmd_pend |=> ##1 s_q.st == ST_OPER)
      else $error("start command not obeyed");
   a_bad_cmd: assert property (@(posedge clk) disable iff (!resetn)
      rx_valid && rx_id == ID_NMT && !cmd_known && !s_q.cmd_pend && is_run
      |=> ##1 s_q.st == $past(s_q.st, 2)) else $error("unknown command changed state");
   a_pdo_gate: assert property (@(posedge clk) disable iff (!resetn)
      pdo_rx_valid |-> $past(s_q.st == ST_OPER)) else $error("pdo outside operational");
   a_sdo_gate: assert property (@(posedge clk) disable iff (!resetn)
      sdo_rx_valid || sync_pulse |-> $past(comm_ok)) else $error("sdo or sync when gated");
   a_emcy_frame: assert property (@(posedge clk) disable iff (!resetn)
      tx_valid && tx_id == ID_EMCY_BASE + {4'h0, node_id} |-> tx_len == 4'h8 &&
      tx_data[23:16] == err_reg) else $error("emergency frame malformed");
   a_hb_paced: assert property (@(posedge clk) disable iff (!resetn)
      $rose(s_q.hb_pend) |-> $past(s_q.hb_div) == 32'(TICK_CYCLES - 1))
      else $error("heartbeat off the tick");
   a_no_reply: assert property (@(posedge clk) disable iff (!resetn)
      $rose(tx_valid) |-> tx_id[10:7] == FC_SYNC_EMCY || tx_id[10:7] == FC_ERRCTL)
      else $error("unexpected frame sent");
   // the rest guard the state sequencing, the gating seen from the outputs, the error register values and the heartbeat frame length
   a_init_entry: assert property (@(posedge clk)
      !resetn |=> s_q.st == ST_RST_APP) else $error("reset did not enter initialization");
   a_app_phase: assert property (@(posedge clk) disable iff (!resetn)
      s_q.st == ST_RST_APP |=> app_reset) else $error("application reset not signalled");
   a_boot_auto: assert property (@(posedge clk) disable iff (!resetn)
      s_q.st == ST_BOOT |=> s_q.st == ST_PREOP) else $error("boot did not reach pre-operational");
   a_stop_cmd: assert property (@(posedge clk) disable iff (!resetn)
      rx_valid && rx_id == ID_NMT && rx_byte0 == CS_STOP && addr_ok && is_run &&
      !sync_mode && !s_q.cmd_pend |=> ##1 s_q.st == ST_STOP) else $error("stop not obeyed");
   a_preop_cmd: assert property (@(posedge clk) disable iff (!resetn)
      rx_valid && rx_id == ID_NMT && rx_byte0 == CS_PREOP && addr_ok && is_run &&
      !sync_mode && !s_q.cmd_pend |=> ##1 s_q.st == ST_PREOP) else $error("preop not obeyed");
   a_rst_com_cmd: assert property (@(posedge clk) disable iff (!resetn)
      rx_valid && rx_id == ID_NMT && rx_byte0 == CS_RST_COM && addr_ok && is_run &&
      !sync_mode && !s_q.cmd_pend |=> ##1 s_q.st == ST_RST_COM) else $error("com reset missed");
   a_rst_app_cmd: assert property (@(posedge clk) disable iff (!resetn)
      rx_valid && rx_id == ID_NMT && rx_byte0 == CS_RST_APP && addr_ok && is_run &&
      !sync_mode && !s_q.cmd_pend |=> ##1 s_q.st == ST_RST_APP) else $error("app reset missed");
   a_sync_hold: assert property (@(posedge clk) disable iff (!resetn)
      is_run && s_q.cmd_pend && sync_mode && !(rx_valid && rx_id == ID_SYNC) |=>
      $stable(s_q.st)) else $error("held command applied without sync");
   a_time_gate: assert property (@(posedge clk) disable iff (!resetn)
      time_valid |-> $past(comm_ok)) else $error("time stamp when gated");
   a_stop_quiet: assert property (@(posedge clk) disable iff (!resetn)
      s_q.st == ST_STOP |=> !pdo_rx_valid && !sdo_rx_valid) else $error("object in stopped");
   a_err_values: assert property (@(posedge clk) disable iff (!resetn)
      err_reg == ERREG_NONE || err_reg == ERREG_GENERIC || err_reg == ERREG_INTERNAL)
      else $error("error register out of range");
   a_hb_frame: assert property (@(posedge clk) disable iff (!resetn)
      tx_valid && tx_id == ID_HB_BASE + {4'h0, node_id} |-> tx_len == 4'h1)
      else $error("heartbeat frame malformed");
endmodule

// *** verif/cnm_master_model.sv ***
`timescale 1ns/100ps
module cnm_master_model
   import cnm_pkg::*;
(
   input wire logic clk,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [10:0] tx_id,
   input wire logic [63:0] tx_data,
   output logic tx_ready,
   output logic rx_valid,
   output logic [10:0] rx_id,
   output logic [7:0] rx_byte0,
   output logic [7:0] rx_byte1
);
   logic [2:0] div_q = 3'h0;
   logic [10:0] last_id = 11'h000;
   logic [63:0] last_data = 64'h0;
   int tx_n = 0;
   initial begin
      tx_ready = 1'b1;
      rx_valid = 1'b0;
      rx_id = 11'h7FF;
      rx_byte0 = 8'hFF;
      rx_byte1 = 8'hFF;
   end
   // a slow sink takes one cycle in eight, so a pending frame has to stand
   always @(negedge clk) begin
      div_q <= div_q + 3'h1;
      tx_ready <= !slow || div_q == 3'h0;
   end
   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready) begin
         tx_n <= tx_n + 1;
         last_id <= tx_id;
         last_data <= tx_data;
      end
   end
   task automatic send(input logic [10:0] id, input logic [7:0] b0, input logic [7:0] b1);
      @(negedge clk);
      rx_valid = 1'b1;
      rx_id = id;
      rx_byte0 = b0;
      rx_byte1 = b1;
      @(negedge clk);
      rx_valid = 1'b0;
      // released lines must not keep showing the old frame
      rx_id = ~id;
      rx_byte0 = ~b0;
      rx_byte1 = ~b1;
      // only one request outstanding; the gap covers the command latency
      repeat (3) @(negedge clk);
   endtask
   task automatic send_sync;
      send(ID_SYNC, 8'h00, 8'h00);
   endtask
endmodule

// *** verif/canopen_nmt_slave_control_test.sv ***
`timescale 1ns/100ps
module canopen_nmt_slave_control_test;
   import cnm_pkg::*;
   localparam int TK = 4;
   localparam logic [6:0] NODE = 7'h05;
   typedef struct {
      logic [10:0] id;
      logic [7:0] b0;
      logic [7:0] b1;
      logic [5:0] st;
      int tx;
      logic [3:0] mask;
   } cnm_row_t;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [6:0] node_id = NODE;
   logic sync_mode = 1'b0;
   logic [15:0] hb_prod_ms = 16'h0000;
   logic [15:0] hb_cons_ms = 16'h0000;
   logic [6:0] hb_cons_node = 7'h09;
   logic fault = 1'b0;
   logic [15:0] fault_code = 16'h0000;
   logic [39:0] vendor_code = 40'h0504030201;
   logic [15:0] od_index = 16'h0000;
   logic slow = 1'b0;
   logic rx_valid, tx_ready, tx_valid, app_reset, pdo_rx_valid, sdo_rx_valid;
   logic sync_pulse, time_valid, hb_lost, err_state;
   logic [10:0] rx_id, tx_id;
   logic [7:0] rx_byte0, rx_byte1, err_reg, od_data;
   logic [3:0] tx_len;
   logic [63:0] tx_data;
   logic [5:0] nmt_state;
   logic [1:0] pdo_rx_num;
   logic [3:0] seen_q = 4'h0;
   int n_errors = 0;
   int cmp_count = 0;
   // mask bits: pdo, sdo, sync, time
   cnm_row_t rows [20] = '{
      '{11'h605, 8'h40, 8'h00, 6'h08, 0, 4'h4},
      '{11'h080, 8'h00, 8'h00, 6'h08, 0, 4'h2},
      '{11'h100, 8'h00, 8'h00, 6'h08, 0, 4'h1},
      '{11'h205, 8'h11, 8'h22, 6'h08, 0, 4'h0},
      '{11'h000, 8'h01, 8'h05, 6'h10, 0, 4'h0},
      '{11'h205, 8'h11, 8'h22, 6'h10, 0, 4'h8},
      '{11'h505, 8'h11, 8'h22, 6'h10, 0, 4'h8},
      '{11'h606, 8'h40, 8'h00, 6'h10, 0, 4'h0},
      '{11'h000, 8'h02, 8'h00, 6'h20, 0, 4'h0},
      '{11'h605, 8'h40, 8'h00, 6'h20, 0, 4'h0},
      '{11'h080, 8'h00, 8'h00, 6'h20, 0, 4'h0},
      '{11'h205, 8'h11, 8'h22, 6'h20, 0, 4'h0},
      '{11'h000, 8'h01, 8'h06, 6'h20, 0, 4'h0},
      '{11'h000, 8'h03, 8'h05, 6'h20, 0, 4'h0},
      '{11'h001, 8'h01, 8'h05, 6'h20, 0, 4'h0},
      '{11'h000, 8'h80, 8'h05, 6'h08, 0, 4'h0},
      '{11'h000, 8'h01, 8'h00, 6'h10, 0, 4'h0},
      '{11'h000, 8'h82, 8'h05, 6'h08, 1, 4'h0},
      '{11'h000, 8'h01, 8'h05, 6'h10, 0, 4'h0},
      '{11'h000, 8'h81, 8'h00, 6'h08, 1, 4'h0}
   };
   always #50 clk = ~clk;
   always @(posedge clk) seen_q <= seen_q | {pdo_rx_valid, sdo_rx_valid, sync_pulse, time_valid};
   cnm_nmt_slave #(.TICK_CYCLES(TK)) dut_u (.clk, .resetn, .node_id, .sync_mode, .hb_prod_ms,
      .hb_cons_ms, .hb_cons_node, .rx_valid, .rx_id, .rx_byte0, .rx_byte1, .fault, .fault_code,
      .vendor_code, .od_index, .tx_ready, .tx_valid, .tx_id, .tx_len, .tx_data, .nmt_state,
      .app_reset, .pdo_rx_valid, .pdo_rx_num, .sdo_rx_valid, .sync_pulse, .time_valid, .err_reg,
      .od_data, .hb_lost, .err_state);
   cnm_master_model mdl_u (.clk, .slow, .tx_valid, .tx_id, .tx_data, .tx_ready, .rx_valid,
      .rx_id, .rx_byte0, .rx_byte1);
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_tx(input int n0);
      for (int k = 0; k < 60 && mdl_u.tx_n == n0; k++) @(negedge clk);
   endtask
   task automatic conclude;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      $display("[ERR] watchdog expired");
      conclude();
   end
   initial begin
      logic [17:0] path;
      logic [5:0] last;
      logic saw_app;
      int n0;
      repeat (6) @(negedge clk);
      check("reset state", 6'h01, nmt_state);
      resetn = 1'b1;
      path = 18'h0;
      saw_app = 1'b0;
      last = 6'h01;
      repeat (12) begin
         @(negedge clk);
         if (nmt_state !== last) path = {path[11:0], nmt_state};
         last = nmt_state;
         saw_app = saw_app | app_reset;
      end
      check("app reset", 1'b1, saw_app);
      check("init path", {6'h02, 6'h04, 6'h08}, path);
      check("boot count", 1, mdl_u.tx_n);
      check("boot id", ID_HB_BASE + NODE, mdl_u.last_id);
      check("boot byte", HB_BOOT, mdl_u.last_data[7:0]);
      check("boot len", 4'h1, tx_len);
      foreach (rows[i]) begin
         seen_q = 4'h0;
         n0 = mdl_u.tx_n;
         mdl_u.send(rows[i].id, rows[i].b0, rows[i].b1);
         repeat (8) @(negedge clk);
         check("state", rows[i].st, nmt_state);
         check("pulses", rows[i].mask, seen_q);
         check("frames", rows[i].tx, mdl_u.tx_n - n0);
         if (rows[i].mask[3]) check("pdo num", rows[i].id == 11'h205 ? 2'h0 : 2'h3, pdo_rx_num);
      end
      sync_mode = 1'b1;
      mdl_u.send(ID_NMT, CS_START, 8'h00);
      repeat (6) @(negedge clk);
      check("held cmd", 6'h08, nmt_state);
      mdl_u.send_sync();
      check("sync cmd", 6'h10, nmt_state);
      sync_mode = 1'b0;
      slow = 1'b1;
      od_index = OD_ERREG_INDEX;
      for (int k = 0; k < 2; k++) begin
         fault_code = k ? 16'h1000 : 16'hFF10;
         n0 = mdl_u.tx_n;
         fault = 1'b1;
         wait_tx(n0);
         repeat (2) @(negedge clk);
         check("emcy id", ID_EMCY_BASE + NODE, mdl_u.last_id);
         check("emcy data", {vendor_code, k ? 8'h01 : 8'h80, fault_code}, mdl_u.last_data);
         check("err state", 1'b1, err_state);
         check("emcy len", 4'h8, tx_len);
         check("od data", k ? 8'h01 : 8'h80, od_data);
         n0 = mdl_u.tx_n;
         fault = 1'b0;
         wait_tx(n0);
         repeat (2) @(negedge clk);
         check("clear code", EMCY_CLEAR_CODE, mdl_u.last_data[15:0]);
         check("err clear", 1'b0, err_state);
         check("reg clear", ERREG_NONE, err_reg);
      end
      slow = 1'b0;
      hb_prod_ms = 16'h0001;
      n0 = mdl_u.tx_n;
      repeat (40) @(negedge clk);
      check("hb rate", 1'b1, (mdl_u.tx_n - n0 >= 9) && (mdl_u.tx_n - n0 <= 11));
      check("hb frame", {ID_HB_BASE + NODE, HB_OPER}, {mdl_u.last_id, mdl_u.last_data[7:0]});
      hb_prod_ms = 16'h0000;
      hb_cons_ms = 16'h0002;
      repeat (4) mdl_u.send(ID_HB_BASE + 11'h009, HB_OPER, 8'h00);
      check("hb alive", 1'b0, hb_lost);
      repeat (16) @(negedge clk);
      check("hb lost", 1'b1, hb_lost);
      mdl_u.send(ID_HB_BASE + 11'h009, HB_OPER, 8'h00);
      check("hb back", 1'b0, hb_lost);
      conclude();
   end
endmodule
